// ### pkg/pa_defs.svh
// Constants for the primitive assembler
`ifndef PA_DEFS_SVH
`define PA_DEFS_SVH
`define PA_MODE_DOTS 3'h0
`define PA_MODE_SEG_CHAIN 3'h1
`define PA_MODE_SEG_LOOP 3'h2
`define PA_MODE_SEG_PAIRS 3'h3
`define PA_MODE_TRI_CHAIN 3'h4
`define PA_MODE_TRI_PIVOT 3'h5
`define PA_MODE_TRI_INDEP 3'h6
`define PA_KIND_POINT 2'h1
`define PA_KIND_SEGMENT 2'h2
`define PA_KIND_TRIANGLE 2'h3
`define PA_PH_NONE 2'h0
`define PA_PH_ONE 2'h1
`define PA_PH_TWO 2'h2
`define PA_PTR_A 1'h0
`define PA_PTR_B 1'h1
`define PA_FIFO_DEPTH 8
`define PA_VERTEX_WIDTH 32
`endif

// ### pkg/pa_pkg.sv
// Types for the primitive assembler
`default_nettype none
package pa_pkg;
  typedef logic [2:0] pa_mode_type;
  typedef logic [1:0] pa_kind_type;
  typedef logic [1:0] pa_phase_type;
endpackage : pa_pkg
`default_nettype wire

// ### rtl/pa_assembler.sv
// Primitive assembler with its output FIFO
`timescale 1ns/1ps
`default_nettype none
`include "pa_defs.svh"

// ****************************************
// Shift-register FIFO, head always in slot 0
// ****************************************
module pa_fifo
  import pa_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = `PA_FIFO_DEPTH,
  parameter int CW = $clog2(DEPTH + 1)
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [CW-1:0] level
);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [CW-1:0] count_reg, count_next;
  logic valid_reg, valid_next;
  logic push, pop;
  logic [CW-1:0] wr_idx;

  assign in_ready = (count_reg != CW'(DEPTH));
  assign out_valid = valid_reg;
  assign out_data = mem_reg[0];
  assign level = count_reg;
  assign push = in_valid && in_ready;
  assign pop = out_ready && valid_reg;

  always_comb begin
    wr_idx = pop ? count_reg - CW'(1) : count_reg;
    for (int i = 0; i < DEPTH; i++) begin
      if (pop && (i < DEPTH - 1)) begin
        mem_next[i] = mem_reg[(i + 1) % DEPTH];
      end else begin
        mem_next[i] = mem_reg[i];
      end
      if (push && (wr_idx == CW'(i))) begin
        mem_next[i] = in_data;
      end
    end
    count_next = count_reg + CW'(push) - CW'(pop);
    valid_next = (count_next != '0);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      count_reg <= '0;
      valid_reg <= 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
    end else begin
      count_reg <= count_next;
      valid_reg <= valid_next;
      mem_reg <= mem_next;
    end
  end
endmodule : pa_fifo

// ****************************************
// Assembler top
// ****************************************
module pa_assembler
  import pa_pkg::*;
#(
  parameter int VW = `PA_VERTEX_WIDTH,
  parameter int DEPTH = `PA_FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [2:0] draw_mode,
  input wire logic vtx_valid,
  output logic vtx_ready,
  input wire logic [VW-1:0] vtx_data,
  input wire logic vtx_first,
  input wire logic vtx_last,
  output logic prim_valid,
  input wire logic prim_ready,
  output logic [1:0] prim_kind,
  output logic [VW-1:0] prim_v0,
  output logic [VW-1:0] prim_v1,
  output logic [VW-1:0] prim_v2
);
  localparam int FW = 2 + 3 * VW;
  localparam int CW = $clog2(DEPTH + 1);

  pa_mode_type mode_reg, mode_next, eff_mode;
  pa_phase_type phase_reg, phase_next, ph;
  logic ptr_reg, ptr_next, ptr;
  logic close_reg, close_next;
  logic ready_reg, ready_next;
  logic [VW-1:0] va_reg, va_next, vb_reg, vb_next;
  logic acc, push, fifo_in_ready;
  pa_kind_type push_kind;
  logic [VW-1:0] push_v0, push_v1, push_v2;
  logic [FW-1:0] fifo_out;
  logic [CW-1:0] fifo_level;

  assign vtx_ready = ready_reg;
  assign acc = vtx_valid && ready_reg;
  // Draw start discards all assembly history
  assign eff_mode = vtx_first ? draw_mode : mode_reg;
  assign ph = vtx_first ? `PA_PH_NONE : phase_reg;
  assign ptr = vtx_first ? `PA_PTR_A : ptr_reg;

  // ****************************************
  // Assembly step
  // ****************************************
  always_comb begin
    mode_next = acc ? eff_mode : mode_reg;
    phase_next = phase_reg;
    ptr_next = ptr_reg;
    va_next = va_reg;
    vb_next = vb_reg;
    close_next = close_reg;
    push = 1'b0;
    push_kind = `PA_KIND_POINT;
    push_v0 = '0;
    push_v1 = '0;
    push_v2 = '0;
    if (close_reg) begin
      // Loop closure: last vertex back to first
      push = fifo_in_ready;
      push_kind = `PA_KIND_SEGMENT;
      push_v0 = va_reg;
      push_v1 = vb_reg;
      close_next = !fifo_in_ready;
    end else if (acc) begin
      unique case (eff_mode)
        `PA_MODE_DOTS: begin
          push = 1'b1;
          push_v0 = vtx_data;
        end
        `PA_MODE_SEG_CHAIN, `PA_MODE_SEG_LOOP: begin
          va_next = vtx_data;
          phase_next = `PA_PH_ONE;
          if (ph == `PA_PH_NONE) begin
            vb_next = vtx_data;
          end else begin
            push = 1'b1;
            push_kind = `PA_KIND_SEGMENT;
            push_v0 = va_reg;
            push_v1 = vtx_data;
            close_next = vtx_last && (eff_mode == `PA_MODE_SEG_LOOP);
          end
        end
        `PA_MODE_SEG_PAIRS: begin
          if (ph == `PA_PH_NONE) begin
            va_next = vtx_data;
            phase_next = `PA_PH_ONE;
          end else begin
            push = 1'b1;
            push_kind = `PA_KIND_SEGMENT;
            push_v0 = va_reg;
            push_v1 = vtx_data;
            phase_next = `PA_PH_NONE;
          end
        end
        `PA_MODE_TRI_CHAIN, `PA_MODE_TRI_PIVOT, `PA_MODE_TRI_INDEP: begin
          if (ph == `PA_PH_TWO) begin
            push = 1'b1;
            push_kind = `PA_KIND_TRIANGLE;
            push_v0 = va_reg;
            push_v1 = vb_reg;
            push_v2 = vtx_data;
          end
          if (eff_mode == `PA_MODE_TRI_CHAIN) begin
            if (ptr == `PA_PTR_A) begin
              va_next = vtx_data;
            end else begin
              vb_next = vtx_data;
            end
            ptr_next = !ptr;
          end else if (ph == `PA_PH_NONE) begin
            va_next = vtx_data;
          end else begin
            vb_next = vtx_data;
          end
          if (eff_mode == `PA_MODE_TRI_INDEP) begin
            // Groups of three, counter wraps
            phase_next = (ph == `PA_PH_TWO) ? `PA_PH_NONE : ph + 2'h1;
          end else begin
            // Holds at two: first triangle done
            phase_next = (ph == `PA_PH_TWO) ? `PA_PH_TWO : ph + 2'h1;
          end
        end
        default: begin
          phase_next = `PA_PH_NONE;
        end
      endcase
    end
    // Keep room for a vertex and any loop closure
    ready_next = !close_next &&
      ((fifo_level + CW'(push)) <= CW'(DEPTH - 2));
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_reg <= `PA_MODE_DOTS;
      phase_reg <= `PA_PH_NONE;
      ptr_reg <= `PA_PTR_A;
      close_reg <= 1'b0;
      ready_reg <= 1'b0;
      va_reg <= '0;
      vb_reg <= '0;
    end else begin
      mode_reg <= mode_next;
      phase_reg <= phase_next;
      ptr_reg <= ptr_next;
      close_reg <= close_next;
      ready_reg <= ready_next;
      va_reg <= va_next;
      vb_reg <= vb_next;
    end
  end

  // ****************************************
  // Output queue
  // ****************************************
  pa_fifo #(.WIDTH(FW), .DEPTH(DEPTH), .CW(CW)) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data({push_kind, push_v0, push_v1, push_v2}),
    .out_valid(prim_valid),
    .out_ready(prim_ready),
    .out_data(fifo_out),
    .level(fifo_level)
  );
  assign prim_kind = fifo_out[FW-1 -: 2];
  assign prim_v0 = fifo_out[3*VW-1 -: VW];
  assign prim_v1 = fifo_out[2*VW-1 -: VW];
  assign prim_v2 = fifo_out[VW-1:0];

  // ****************************************
  // Checks
  // ****************************************
  property p_dot;
    @(posedge mclk) disable iff (rst)
    acc && !close_reg && eff_mode == `PA_MODE_DOTS |->
      push && push_kind == `PA_KIND_POINT && push_v0 == vtx_data;
  endproperty
  a_dot: assert property (p_dot) else $error("dot not emitted");

  property p_chain_seg;
    @(posedge mclk) disable iff (rst)
    acc && !close_reg && eff_mode == `PA_MODE_SEG_CHAIN && !vtx_first
      |-> push && push_v0 == va_reg && push_v1 == vtx_data;
  endproperty
  a_chain_seg: assert property (p_chain_seg) else $error("bad chain");

  property p_first_silent;
    @(posedge mclk) disable iff (rst)
    acc && !close_reg && vtx_first && eff_mode != `PA_MODE_DOTS |-> !push;
  endproperty
  a_first_silent: assert property (p_first_silent) else $error("spur");

  property p_loop_close;
    @(posedge mclk) disable iff (rst)
    acc && !close_reg && eff_mode == `PA_MODE_SEG_LOOP && !vtx_first &&
      vtx_last |=> close_reg && va_reg == $past(vtx_data) ##[0:16]
      (push && push_kind == `PA_KIND_SEGMENT);
  endproperty
  a_loop_close: assert property (p_loop_close) else $error("no close");

  property p_pair_odd;
    @(posedge mclk) disable iff (rst)
    acc && !close_reg && eff_mode == `PA_MODE_SEG_PAIRS && ph == `PA_PH_NONE
      |-> !push ##1 phase_reg == `PA_PH_ONE;
  endproperty
  a_pair_odd: assert property (p_pair_odd) else $error("pair start");

  property p_ptr_start;
    @(posedge mclk) disable iff (rst)
    acc && !close_reg && vtx_first && eff_mode == `PA_MODE_TRI_CHAIN |=>
      ptr_reg == `PA_PTR_B && va_reg == $past(vtx_data);
  endproperty
  a_ptr_start: assert property (p_ptr_start) else $error("pointer");

  property p_tri_order;
    @(posedge mclk) disable iff (rst)
    acc && !close_reg && eff_mode == `PA_MODE_TRI_CHAIN && ph == `PA_PH_TWO
      |-> push && push_v0 == va_reg && push_v1 == vb_reg &&
      push_v2 == vtx_data;
  endproperty
  a_tri_order: assert property (p_tri_order) else $error("tri order");

  property p_pivot_keep;
    @(posedge mclk) disable iff (rst)
    acc && !close_reg && eff_mode == `PA_MODE_TRI_PIVOT && !vtx_first |=>
      va_reg == $past(va_reg) && vb_reg == $past(vtx_data);
  endproperty
  a_pivot_keep: assert property (p_pivot_keep) else $error("pivot A");

  property p_indep_wrap;
    @(posedge mclk) disable iff (rst)
    acc && !close_reg && eff_mode == `PA_MODE_TRI_INDEP && ph == `PA_PH_TWO
      |=> phase_reg == `PA_PH_NONE;
  endproperty
  a_indep_wrap: assert property (p_indep_wrap) else $error("group");

  property p_no_overflow;
    @(posedge mclk) disable iff (rst)
    acc |-> fifo_in_ready;
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("lost");
endmodule : pa_assembler
`default_nettype wire

// ### verification/pa_sink_model.sv
// Downstream consumer model for the primitive assembler
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Primitive sink with optional stalling
// ****************************************
module pa_sink_model (
  input wire logic mclk,
  input wire logic slow,
  input wire logic prim_valid,
  output logic prim_ready,
  input wire logic [1:0] prim_kind,
  input wire logic [31:0] prim_v0,
  input wire logic [31:0] prim_v1,
  input wire logic [31:0] prim_v2
);
  logic [97:0] got_q[$];
  logic [1:0] tick_reg = 2'h0;
  logic ready_reg = 1'b0;
  assign prim_ready = ready_reg;
  // Slow mode accepts one primitive in four cycles
  always @(negedge mclk) begin
    tick_reg <= tick_reg + 2'h1;
    ready_reg <= !slow || (tick_reg == 2'h3);
  end
  always @(posedge mclk) begin
    if (prim_valid === 1'b1 && prim_ready === 1'b1) begin
      got_q.push_back({prim_kind, prim_v0, prim_v1, prim_v2});
    end
  end
endmodule : pa_sink_model
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking testbench for the primitive assembler
`timescale 1ns/1ps
`default_nettype none
`include "pa_defs.svh"
`define CHK(nm, e, g) begin \
  checked++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); \
  end \
end
// ****************************************
// Bench top
// ****************************************
module tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] draw_mode = 3'h0;
  logic vtx_valid = 1'b0;
  logic vtx_ready;
  logic [31:0] vtx_data = 32'h0;
  logic vtx_first = 1'b0;
  logic vtx_last = 1'b0;
  logic prim_valid, prim_ready;
  logic [1:0] prim_kind;
  logic [31:0] prim_v0, prim_v1, prim_v2;
  logic slow = 1'b0;
  logic saw_full = 1'b0;
  int mismatches = 0;
  int checked = 0;
  logic [97:0] exp_q[$];
  always #10 mclk = ~mclk;
  pa_assembler #(.VW(32), .DEPTH(8)) dut_u (.mclk(mclk), .rst(rst),
    .draw_mode(draw_mode), .vtx_valid(vtx_valid), .vtx_ready(vtx_ready),
    .vtx_data(vtx_data), .vtx_first(vtx_first), .vtx_last(vtx_last),
    .prim_valid(prim_valid), .prim_ready(prim_ready),
    .prim_kind(prim_kind), .prim_v0(prim_v0), .prim_v1(prim_v1),
    .prim_v2(prim_v2));
  pa_sink_model sink_u (.mclk(mclk), .slow(slow), .prim_valid(prim_valid),
    .prim_ready(prim_ready), .prim_kind(prim_kind), .prim_v0(prim_v0),
    .prim_v1(prim_v1), .prim_v2(prim_v2));
  always @(posedge mclk) begin
    if (rst) begin
      saw_full <= 1'b0;
    end else if (vtx_valid === 1'b1 && vtx_ready === 1'b0) begin
      saw_full <= 1'b1;
    end
  end
  function automatic void prim(logic [1:0] k, logic [31:0] a,
                               logic [31:0] b, logic [31:0] c);
    exp_q.push_back({k, a, b, c});
  endfunction : prim
  // Expected primitives of one draw
  function automatic void model(int m, int n, int base, bit closed);
    logic [31:0] va, vb, v;
    bit ptr;
    va = 32'h0;
    vb = 32'h0;
    ptr = 1'b0;
    for (int i = 0; i < n; i++) begin
      v = 32'(base + i);
      case (m)
        0: prim(`PA_KIND_POINT, v, 32'h0, 32'h0);
        1, 2: if (i > 0) prim(`PA_KIND_SEGMENT, v - 1, v, 32'h0);
        3: if (i % 2 == 1) prim(`PA_KIND_SEGMENT, v - 1, v, 32'h0);
        4: begin
          if (i > 1) prim(`PA_KIND_TRIANGLE, va, vb, v);
          if (ptr) vb = v;
          else va = v;
          ptr = !ptr;
        end
        5: begin
          if (i > 1) prim(`PA_KIND_TRIANGLE, va, vb, v);
          if (i == 0) va = v;
          else vb = v;
        end
        6: if (i % 3 == 2) prim(`PA_KIND_TRIANGLE, v - 2, v - 1, v);
        default: ;
      endcase
    end
    if (m == 2 && closed && n > 1) begin
      prim(`PA_KIND_SEGMENT, 32'(base + n - 1), 32'(base), 32'h0);
    end
  endfunction : model
  task automatic send(input logic [2:0] m, input logic [31:0] d,
                      input logic f, input logic l);
    int n = 0;
    @(negedge mclk);
    draw_mode = m;
    vtx_data = d;
    vtx_first = f;
    vtx_last = l;
    vtx_valid = 1'b1;
    while (vtx_ready !== 1'b1 && n < 500) begin
      @(negedge mclk);
      n++;
    end
    @(posedge mclk);
  endtask : send
  task automatic draw(input int m, input int n, input int base,
                      input bit closed);
    for (int i = 0; i < n; i++) begin
      send(3'(m), 32'(base + i), i == 0, closed && i == n - 1);
    end
    model(m, n, base, closed);
  endtask : draw
  task automatic judge(input string nm);
    int w = 0;
    @(negedge mclk);
    vtx_valid = 1'b0;
    vtx_data = ~vtx_data;
    while (sink_u.got_q.size() < exp_q.size() && w < 2000) begin
      @(posedge mclk);
      w++;
    end
    repeat (30) @(posedge mclk);
    `CHK(nm, exp_q.size(), sink_u.got_q.size())
    for (int i = 0; i < exp_q.size() && i < sink_u.got_q.size(); i++) begin
      `CHK(nm, exp_q[i], sink_u.got_q[i])
    end
    `CHK(nm, 1'b0, prim_valid)
    exp_q.delete();
    sink_u.got_q.delete();
  endtask : judge
  task automatic t_all_modes();
    for (int m = 0; m < 8; m++) begin
      draw(m, 7, 256 + 16 * m, 1'b1);
      judge("seven_vertex_draw");
    end
  endtask : t_all_modes
  task automatic t_short();
    for (int m = 0; m < 8; m++) begin
      draw(m, 1, 1024 + 8 * m, 1'b1);
      draw(m, 2, 2048 + 8 * m, 1'b1);
      judge("short_draw");
    end
    draw(6, 5, 3072, 1'b1);
    judge("two_leftover");
  endtask : t_short
  task automatic t_pressure();
    @(negedge mclk);
    slow = 1'b1;
    draw(4, 60, 4096, 1'b1);
    draw(2, 20, 5120, 1'b1);
    judge("stalled_sink");
    `CHK("fifo_refused", 1'b1, saw_full)
    @(negedge mclk);
    slow = 1'b0;
  endtask : t_pressure
  task automatic t_restart();
    draw(2, 3, 8192, 1'b0);
    draw(3, 5, 8448, 1'b1);
    draw(4, 3, 8704, 1'b0);
    draw(4, 5, 8960, 1'b1);
    draw(1, 4, 9216, 1'b0);
    draw(5, 5, 9472, 1'b1);
    judge("aborted_draws");
  endtask : t_restart
  task automatic final_report();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (12) @(negedge mclk);
    `CHK("ready_in_reset", 1'b0, vtx_ready)
    `CHK("valid_in_reset", 1'b0, prim_valid)
    rst = 1'b0;
    t_all_modes();
    t_short();
    t_pressure();
    t_restart();
    final_report();
  end
  // Watchdog against a hung handshake
  initial begin
    #(20 * 60000);
    mismatches++;
    final_report();
  end
endmodule : tb_top
`default_nettype wire
